// ===== inc/vic_defs.vh
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH
`define CTRL0_IDX 8'h0b
`define CTRL1_IDX 8'h1e
`define MULTI_FUNCTION_IRQ_CONTROL_IDX 8'h2f
`define STACK_DEPTH 5'h10
`define PHASE_DIV 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define VEC_PIN_A 14'h0004
`define VEC_PIN_B 14'h0008
`define VEC_CNT0 14'h000c
`define VEC_CNT1 14'h0010
`define VEC_SER 14'h0014
`define VEC_COMB 14'h0018
`define C0_GIE 0
`define C0_PIN_A_EN 1
`define C0_PIN_B_EN 2
`define C0_CNT0_EN 3
`define C0_PIN_A_F 4
`define C0_PIN_B_F 5
`define C0_CNT0_F 6
`define C1_CNT1_EN 0
`define C1_SER_EN 1
`define C1_COMB_EN 2
`define C1_CNT1_F 4
`define C1_SER_F 5
`define C1_COMB_F 6
`define MF_CNT2_EN 0
`define MF_TB_EN 1
`define MF_RTC_EN 2
`define MF_CNT2_F 4
`define MF_TB_F 5
`define MF_RTC_F 6
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define MULTI_FUNCTION_IRQ_CONTROL_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/vectored_interrupt_controller.v
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"
module vectored_interrupt_controller #(
  parameter [1:0] EDGE_MODE = `EDGE_FALL
) (
  input wire clock_i,
  input wire rst_i,
  input wire ext_irq_pin_a_i,
  input wire ext_irq_pin_b_i,
  input wire counter0_overflow_i,
  input wire counter1_overflow_i,
  input wire transmit_empty_event_i,
  input wire receive_available_event_i,
  input wire transmit_quiet_event_i,
  input wire overrun_event_i,
  input wire address_match_event_i,
  input wire counter2_overflow_i,
  input wire rtc_timeout_i,
  input wire timebase_timeout_i,
  input wire irq_exit_with_enable_i,
  input wire plain_subroutine_exit_i,
  input wire subroutine_call_i,
  input wire service_done_i,
  output reg service_request_o,
  output reg [13:0] service_vector_o,
  output reg second_cycle_phase_o,
  output reg [4:0] return_stack_pointer_o,
  output reg wake_o,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // byte address is four times the printed index
  function [1:0] decode;
    input [31:0] addr;
    begin
      if (addr == {22'h00_0000, `CTRL0_IDX, 2'b00})
        decode = 2'd1;
      else if (addr == {22'h00_0000, `CTRL1_IDX, 2'b00})
        decode = 2'd2;
      else if (addr == {22'h00_0000, `MULTI_FUNCTION_IRQ_CONTROL_IDX, 2'b00})
        decode = 2'd3;
      else
        decode = 2'd0;
    end
  endfunction

  function edge_hit;
    input prev;
    input cur;
    begin
      case (EDGE_MODE)
        `EDGE_RISE: edge_hit = ~prev & cur;
        `EDGE_BOTH: edge_hit = prev ^ cur;
        default: edge_hit = prev & ~cur;
      endcase
    end
  endfunction

  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [7:0] multi_function_irq_control;
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  reg prev_a;
  reg prev_b;
  reg [1:0] phase_cnt;
  reg phase_tick;
  reg [31:0] aw_addr;
  reg aw_held;
  reg [7:0] w_data;
  reg w_lane0;
  reg w_held;
  reg [2:0] pick;
  reg any_pick;
  reg [7:0] next_ctrl0;
  reg [7:0] next_ctrl1;
  reg [7:0] next_multi_function_irq_control;

  wire [1:0] wsel = decode(aw_addr);
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire edge_a = edge_hit(prev_a, sync_a[1]);
  wire edge_b = edge_hit(prev_b, sync_b[1]);
  wire serial_ev = transmit_empty_event_i | receive_available_event_i |
    transmit_quiet_event_i | overrun_event_i | address_match_event_i;
  wire stack_full = (return_stack_pointer_o == `STACK_DEPTH);
  wire [5:0] pending = {
    ctrl1[`C1_COMB_F] & ctrl1[`C1_COMB_EN],
    ctrl1[`C1_SER_F] & ctrl1[`C1_SER_EN],
    ctrl1[`C1_CNT1_F] & ctrl1[`C1_CNT1_EN],
    ctrl0[`C0_CNT0_F] & ctrl0[`C0_CNT0_EN],
    ctrl0[`C0_PIN_B_F] & ctrl0[`C0_PIN_B_EN],
    ctrl0[`C0_PIN_A_F] & ctrl0[`C0_PIN_A_EN]};
  // only one acknowledge in flight; the core answers with service_done_i
  wire take = phase_tick & ctrl0[`C0_GIE] & ~stack_full &
    ~service_request_o & any_pick;
  wire [13:0] vec_table [0:5];
  assign vec_table[0] = `VEC_PIN_A;
  assign vec_table[1] = `VEC_PIN_B;
  assign vec_table[2] = `VEC_CNT0;
  assign vec_table[3] = `VEC_CNT1;
  assign vec_table[4] = `VEC_SER;
  assign vec_table[5] = `VEC_COMB;

  always @*
  begin
    pick = 3'd0;
    any_pick = 1'b0;
    if (pending[0])
    begin
      pick = 3'd0;
      any_pick = 1'b1;
    end
    else if (pending[1])
    begin
      pick = 3'd1;
      any_pick = 1'b1;
    end
    else if (pending[2])
    begin
      pick = 3'd2;
      any_pick = 1'b1;
    end
    else if (pending[3])
    begin
      pick = 3'd3;
      any_pick = 1'b1;
    end
    else if (pending[4])
    begin
      pick = 3'd4;
      any_pick = 1'b1;
    end
    else if (pending[5])
    begin
      pick = 3'd5;
      any_pick = 1'b1;
    end
  end

  // software write first, hardware set last so an event wins over a clear
  always @*
  begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_multi_function_irq_control = multi_function_irq_control;
    if (do_write && w_lane0)
    begin
      case (wsel)
        2'd1: next_ctrl0 = w_data;
        2'd2: next_ctrl1 = {1'b0, w_data[6:4], 1'b0, w_data[2:0]};
        2'd3: next_multi_function_irq_control = {1'b0, w_data[6:4], 1'b0, w_data[2:0]};
        default: next_ctrl0 = next_ctrl0;
      endcase
    end
    if (take)
    begin
      next_ctrl0[`C0_GIE] = 1'b0;
      case (pick)
        3'd0: next_ctrl0[`C0_PIN_A_F] = 1'b0;
        3'd1: next_ctrl0[`C0_PIN_B_F] = 1'b0;
        3'd2: next_ctrl0[`C0_CNT0_F] = 1'b0;
        3'd3: next_ctrl1[`C1_CNT1_F] = 1'b0;
        3'd4: next_ctrl1[`C1_SER_F] = 1'b0;
        default: next_ctrl1[`C1_COMB_F] = 1'b0;
      endcase
    end
    if (irq_exit_with_enable_i)
      next_ctrl0[`C0_GIE] = 1'b1;
    // flags stay until serviced or written
    if (edge_a)
      next_ctrl0[`C0_PIN_A_F] = 1'b1;
    if (edge_b)
      next_ctrl0[`C0_PIN_B_F] = 1'b1;
    if (counter0_overflow_i)
      next_ctrl0[`C0_CNT0_F] = 1'b1;
    if (counter1_overflow_i)
      next_ctrl1[`C1_CNT1_F] = 1'b1;
    if (serial_ev)
      next_ctrl1[`C1_SER_F] = 1'b1;
    if (counter2_overflow_i)
      next_multi_function_irq_control[`MF_CNT2_F] = 1'b1;
    if (timebase_timeout_i)
      next_multi_function_irq_control[`MF_TB_F] = 1'b1;
    if (rtc_timeout_i)
      next_multi_function_irq_control[`MF_RTC_F] = 1'b1;
    if ((counter2_overflow_i & multi_function_irq_control[`MF_CNT2_EN]) |
        (timebase_timeout_i & multi_function_irq_control[`MF_TB_EN]) |
        (rtc_timeout_i & multi_function_irq_control[`MF_RTC_EN]))
      next_ctrl1[`C1_COMB_F] = 1'b1;
  end

  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl0 <= `CTRL0_RESET;
      ctrl1 <= `CTRL1_RESET;
      multi_function_irq_control <= `MULTI_FUNCTION_IRQ_CONTROL_RESET;
      sync_a <= 2'b11;
      sync_b <= 2'b11;
      prev_a <= 1'b1;
      prev_b <= 1'b1;
      phase_cnt <= 2'd0;
      phase_tick <= 1'b0;
      second_cycle_phase_o <= 1'b0;
      service_request_o <= 1'b0;
      service_vector_o <= 14'h0000;
      return_stack_pointer_o <= 5'h00;
      wake_o <= 1'b0;
    end
    else
    begin
      sync_a <= {sync_a[0], ext_irq_pin_a_i};
      sync_b <= {sync_b[0], ext_irq_pin_b_i};
      prev_a <= sync_a[1];
      prev_b <= sync_b[1];
      // four system clocks per instruction cycle
      phase_cnt <= phase_cnt + 2'd1;
      phase_tick <= (phase_cnt == `PHASE_DIV - 2'd1);
      second_cycle_phase_o <= (phase_cnt == `PHASE_DIV - 2'd1);
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      multi_function_irq_control <= next_multi_function_irq_control;
      if (take)
      begin
        service_request_o <= 1'b1;
        service_vector_o <= vec_table[pick];
      end
      else if (service_done_i)
        service_request_o <= 1'b0;
      // only the program counter goes on the stack
      if ((take | subroutine_call_i) & ~stack_full)
        return_stack_pointer_o <= return_stack_pointer_o + 5'h01;
      else if ((irq_exit_with_enable_i | plain_subroutine_exit_i) &&
               return_stack_pointer_o != 5'h00)
        return_stack_pointer_o <= return_stack_pointer_o - 5'h01;
      wake_o <= |{ctrl0[6:4], ctrl1[6:4], multi_function_irq_control[6:4]};
    end
  end

  // axi4-lite slave; one read outstanding at most, a second write can be accepted while a write response waits
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_addr <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == 2'd0) ? `RESP_SLVERR : `RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        case (decode(s_axi_araddr))
          2'd1: s_axi_rdata <= {24'h00_0000, ctrl0};
          2'd2: s_axi_rdata <= {24'h00_0000, ctrl1};
          2'd3: s_axi_rdata <= {24'h00_0000, multi_function_irq_control};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
        s_axi_rresp <= (decode(s_axi_araddr) == 2'd0) ?
          `RESP_SLVERR : `RESP_OKAY;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic request_i,
  input wire logic slow_i,
  output logic done_o
);
  logic [3:0] cnt;
  // slow answers keep the request standing for several cycles
  always @(posedge clock_i)
  begin
    if (rst_i || !request_i || done_o)
    begin
      cnt <= 4'h0;
      done_o <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 4'h1;
      done_o <= cnt == (slow_i ? 4'h6 : 4'h0);
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.vh"
module test_vectored_interrupt_controller;
  localparam logic [31:0] a0 = {22'h0, `CTRL0_IDX, 2'h0};
  localparam logic [31:0] a1 = {22'h0, `CTRL1_IDX, 2'h0};
  localparam logic [31:0] a2 = {22'h0, `MULTI_FUNCTION_IRQ_CONTROL_IDX, 2'h0};
  logic clock_i;
  logic rst_i = 1'b1;
  logic [11:0] ev = 12'h000;
  logic [2:0] cr = 3'h0;
  logic slow = 1'b0;
  logic [31:0] aw = 32'h0000_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] ar = 32'h0000_0000;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bw = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic dn, rq, wk, awr, wrd, bv, arr, rv;
  logic [13:0] vc;
  logic [4:0] sp;
  logic [1:0] br, rs, resp;
  logic [31:0] rdt;
  logic [15:0] r = 16'h2196;
  int mismatches = 0;
  int compares = 0;
  // pins idle high, so an event bit falls the pin
  vectored_interrupt_controller u_dut (
    .clock_i(clock_i), .rst_i(rst_i),
    .ext_irq_pin_a_i(~ev[0]), .ext_irq_pin_b_i(~ev[1]),
    .counter0_overflow_i(ev[2]), .counter1_overflow_i(ev[3]),
    .transmit_empty_event_i(ev[4]), .receive_available_event_i(ev[5]),
    .transmit_quiet_event_i(ev[6]), .overrun_event_i(ev[7]),
    .address_match_event_i(ev[8]), .counter2_overflow_i(ev[9]),
    .rtc_timeout_i(ev[10]), .timebase_timeout_i(ev[11]),
    .irq_exit_with_enable_i(cr[0]), .plain_subroutine_exit_i(cr[1]),
    .subroutine_call_i(cr[2]), .service_done_i(dn),
    .service_request_o(rq), .service_vector_o(vc),
    .second_cycle_phase_o(), .return_stack_pointer_o(sp), .wake_o(wk),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bw), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rs),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  cpu_core_model u_core (.clock_i(clock_i), .rst_i(rst_i), .request_i(rq),
    .slow_i(slow), .done_o(dn));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ev_exp(input int i);
    int b;
    b = i < 3 ? 4 + i : i == 3 || i == 9 ? 4 : i == 10 ? 6 : 5;
    return (i > 8 ? 32'h0000_0007 : 32'h0000_0000) | 32'h0000_0001 << b;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge clock_i);
    aw <= a;
    wd <= {24'h00_0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
    end
    while (!bv);
    bw <= 1'b1;
    @(posedge clock_i);
    resp = br;
    bw <= 1'b0;
  endtask
  task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    ar <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (arr)
        arv <= 1'b0;
    end
    while (!rv);
    rr <= 1'b1;
    @(posedge clock_i);
    resp = rs;
    rr <= 1'b0;
    chk(rdt, exp);
  endtask
  task automatic cpu(input int b);
    @(posedge clock_i);
    cr[b] <= 1'b1;
    @(posedge clock_i);
    cr <= 3'h0;
  endtask
  task automatic wait_req(input logic v);
    int n = 0;
    while (rq !== v && n < 300)
    begin
      @(posedge clock_i);
      n++;
    end
    chk(rq, v);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    reg_rd(a0, `CTRL0_RESET);
    reg_rd(a1, `CTRL1_RESET);
    reg_rd(a2, `MULTI_FUNCTION_IRQ_CONTROL_RESET);
    reg_rd(32'h0000_0100, 32'h0000_0000);
    chk(resp, `RESP_SLVERR);
    reg_wr(32'h0000_0104, r[7:0]);
    chk(resp, `RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      reg_wr(a0, r[7:0] & 8'h7e);
      reg_rd(a0, {24'h00_0000, r[7:0] & 8'h7e});
      reg_wr(a1, r[15:8]);
      reg_rd(a1, {24'h00_0000, r[15:8] & 8'h77});
      reg_wr(a2, r[7:0] & 8'h70);
      reg_rd(a2, {24'h00_0000, r[7:0] & 8'h70});
    end
    $display("test 1 done");
    for (int i = 0; i < 12; i++)
    begin
      reg_wr(a0, 8'h00);
      reg_wr(a1, 8'h00);
      reg_wr(a2, 8'h07);
      chk(wk, 1'b0);
      ev[i] <= 1'b1;
      repeat (3) @(posedge clock_i);
      ev <= 12'h000;
      repeat (6) @(posedge clock_i);
      chk(wk, 1'b1);
      reg_rd(i < 3 ? a0 : i < 9 ? a1 : a2, ev_exp(i));
      if (i > 8)
        reg_rd(a1, 32'h0000_0040);
    end
    $display("test 2 done");
    reg_wr(a1, 8'h44);
    reg_wr(a0, 8'h01);
    wait_req(1'b1);
    chk(vc, `VEC_COMB);
    wait_req(1'b0);
    reg_rd(a2, 32'h0000_0027);
    reg_rd(a1, 32'h0000_0004);
    cpu(1);
    $display("test 3 done");
    reg_wr(a2, 8'h00);
    reg_wr(a1, 8'h77);
    reg_wr(a0, 8'h7f);
    for (int k = 0; k < 6; k++)
    begin
      r = lfsr(r);
      slow <= r[0];
      wait_req(1'b1);
      chk(vc, 14'(4 * k + 4));
      chk(sp, 5'h01);
      wait_req(1'b0);
      repeat (12) @(posedge clock_i);
      chk(rq, 1'b0);
      if (k == 0)
      begin
        reg_rd(a0, 32'h0000_006e);
        cpu(1);
        repeat (12) @(posedge clock_i);
        chk(rq, 1'b0);
        chk(sp, 5'h00);
        cpu(2);
      end
      cpu(0);
    end
    $display("test 4 done");
    reg_wr(a0, 8'h00);
    for (int k = 0; k < 16; k++)
      cpu(2);
    reg_wr(a1, 8'h11);
    chk(sp, `STACK_DEPTH);
    reg_wr(a0, 8'h01);
    repeat (12) @(posedge clock_i);
    chk(rq, 1'b0);
    reg_rd(a1, 32'h0000_0011);
    cpu(1);
    wait_req(1'b1);
    chk(vc, `VEC_CNT1);
    chk(sp, `STACK_DEPTH);
    wait_req(1'b0);
    $display("test 5 done");
    // routine re-enables itself to let a nested request through
    reg_wr(a1, 8'h22);
    cpu(1);
    reg_wr(a0, 8'h01);
    wait_req(1'b1);
    chk(vc, `VEC_SER);
    chk(sp, `STACK_DEPTH);
    wait_req(1'b0);
    $display("test 6 done");
    end_sim;
  end
endmodule
`default_nettype wire

// ===== tb/vic_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vic_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic service_done_i,
  input wire logic service_request_o,
  input wire logic [13:0] service_vector_o,
  input wire logic second_cycle_phase_o,
  input wire logic [4:0] return_stack_pointer_o,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_gap;
    !second_cycle_phase_o [*3] ##1 second_cycle_phase_o;
  endsequence
  sequence s_ack;
    $rose(service_request_o);
  endsequence
  property p_tick;
    second_cycle_phase_o |=> s_gap;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_room;
    s_ack |-> $past(return_stack_pointer_o) < 5'h10;
  endproperty
  a_room: assert property (p_room) else $error("ack on full");
  property p_push;
    s_ack |-> return_stack_pointer_o == $past(return_stack_pointer_o) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_vec;
    s_ack |-> service_vector_o inside {14'h0004, 14'h0008, 14'h000c,
      14'h0010, 14'h0014, 14'h0018};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_hold;
    service_request_o && !service_done_i |=>
      service_request_o && $stable(service_vector_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_drop;
    service_request_o && service_done_i |=> !service_request_o;
  endproperty
  a_drop: assert property (p_drop) else $error("request stuck");
  property p_limit;
    return_stack_pointer_o > 5'h0f |=> return_stack_pointer_o <= 5'h10;
  endproperty
  a_limit: assert property (p_limit) else $error("stack overrun");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
endmodule
bind vectored_interrupt_controller vic_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .service_done_i(service_done_i),
  .service_request_o(service_request_o),
  .service_vector_o(service_vector_o),
  .second_cycle_phase_o(second_cycle_phase_o),
  .return_stack_pointer_o(return_stack_pointer_o),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
